// ---- src/endpoint_irq_and_buffer_read.sv ----
// Command port logic: interrupt source register, endpoint select, buffer read
// Summary of operation
// - Interrupt read returns low byte, then high
// - Hub status change sets bit 15
// - Function 3,2,1 status changes set bits 14-12
// - Function 3 endpoints on bits 11 to 8
// - Function 2 endpoints on bits 7 to 4
// - Function 1 endpoints on bits 3 to 0
// - Hub status read clears bit 15
// - Port status read clears its change bit
// - Select-and-clear clears that endpoint's interrupt
// - Codes 40-4B select and clear endpoints 0-11
// - Codes 00-0B select endpoint, reset pointer
// - Optional read after select returns state byte
// - Bit 4 set on NAK, cleared on ACK
// - NAK bit only control endpoints, when enabled
// - Config bit 0 enables NAK interrupts, resets 1
// - Bit 3 set on overwrite, cleared by select-clear
// - Bit 2 setup seen, zero for IN buffers
// - Bit 1 shows endpoint stalled
// - Bit 0 shows buffer full
// - Buffer read streams selected endpoint buffer
// - Pointer advances per byte, select resets it
// - Pointer kept across other commands
// - Buffer holds flags, count, then data
// - Hub endpoints never raise interrupts here
`timescale 1ns/1ps
`include "ep_cmd_params.svh"

module endpoint_irq_and_buffer_read (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic CMD_WR_I,
  input wire logic [7:0] CMD_I,
  input wire logic DATA_WR_I,
  input wire logic [7:0] DATA_I,
  input wire logic DATA_RD_I,
  output logic [7:0] DATA_O,
  output logic DATA_VLD_O,
  output logic IRQ_O,
  input wire logic [7:0] HUB_STATUS_I,
  input wire logic [23:0] PORT_STATUS_I,
  input wire logic HUB_CHG_I,
  input wire logic [2:0] PORT_CHG_I,
  input wire logic [11:0] EP_DONE_I,
  input wire logic [11:0] EP_NAK_I,
  input wire logic [11:0] EP_ACK_I,
  input wire logic [11:0] EP_SETUP_I,
  input wire logic [11:0] EP_OVW_I,
  input wire logic [11:0] EP_STALL_I,
  input wire logic [11:0] EP_FULL_I,
  input wire logic BUF_WR_I,
  input wire logic [3:0] BUF_WR_EP_I,
  input wire logic [4:0] BUF_WR_ADDR_I,
  input wire logic [7:0] BUF_WR_DATA_I
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [15:0] irq_q; // Interrupt source register
  logic [7:0] cfg_q; // Configuration byte
  ep_cmd_pkg::data_mode_t mode_q; // Pending data phase
  logic [3:0] sel_q; // Selected endpoint
  logic [4:0] ptr_q; // Buffer pointer
  logic [1:0] port_q; // Port addressed by status read
  logic [11:0] nak_q; // NAK sent flags
  logic [11:0] ovw_q; // Overwritten by setup flags
  logic [11:0] setup_q; // Setup token flags
  logic [7:0] buf_mem [0:`BUF_DEPTH-1]; // Endpoint buffers
  logic is_sel; // Plain select command
  logic is_selclr; // Select and clear command
  logic [11:0] clr_ep; // One-hot endpoint clear
  logic rd_hub; // Hub status byte read
  logic [2:0] rd_port; // Port status byte read
  logic [7:0] state_byte; // Selected endpoint state
  logic [11:0] ep_irq_set; // Endpoint interrupt causes

  // ==========================================================================
  // Command decode
  // ==========================================================================
  // Range checks on the command code
  always_comb
  begin
    is_sel = CMD_WR_I && (CMD_I <= `CMD_SEL_LAST);
    is_selclr = CMD_WR_I && (CMD_I >= `CMD_SELCLR_FIRST) && (CMD_I <= `CMD_SELCLR_LAST);
    rd_hub = DATA_RD_I && (mode_q == ep_cmd_pkg::MODE_HUB_STAT);
    rd_port = 3'h0;
    if (DATA_RD_I && (mode_q == ep_cmd_pkg::MODE_PORT_STAT))
    begin
      rd_port[port_q] = 1'b1;
    end
    clr_ep = 12'h000;
    if (is_selclr)
    begin
      clr_ep[CMD_I[3:0]] = 1'b1;
    end
  end
  // Data phase mode and endpoint selection
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      mode_q <= ep_cmd_pkg::MODE_IDLE;
      sel_q <= 4'h0;
      port_q <= 2'h0;
    end
    else if (CMD_WR_I)
    begin
      if (is_sel || is_selclr)
      begin
        sel_q <= CMD_I[3:0];
        mode_q <= ep_cmd_pkg::MODE_EP_STATE;
      end
      else if ((CMD_I >= `CMD_PORT_FIRST) && (CMD_I <= `CMD_PORT_LAST))
      begin
        mode_q <= ep_cmd_pkg::MODE_PORT_STAT;
        port_q <= CMD_I[1:0];
      end
      else
      begin
        // Single code commands; unknown codes end any data phase
        case (CMD_I)
          `CMD_IRQ_READ: mode_q <= ep_cmd_pkg::MODE_IRQ_LO;
          `CMD_BUF_READ: mode_q <= ep_cmd_pkg::MODE_BUF_READ;
          `CMD_SET_MODE: mode_q <= ep_cmd_pkg::MODE_CFG_WRITE;
          `CMD_HUB_STAT: mode_q <= ep_cmd_pkg::MODE_HUB_STAT;
          default: mode_q <= ep_cmd_pkg::MODE_IDLE; // Commands handled elsewhere
        endcase
      end
    end
    else if (DATA_RD_I)
    begin
      case (mode_q)
        ep_cmd_pkg::MODE_IRQ_LO: mode_q <= ep_cmd_pkg::MODE_IRQ_HI;
        ep_cmd_pkg::MODE_BUF_READ: mode_q <= ep_cmd_pkg::MODE_BUF_READ; // Streams on
        default: mode_q <= ep_cmd_pkg::MODE_IDLE; // Single byte phases end
      endcase
    end
    else if (DATA_WR_I && (mode_q == ep_cmd_pkg::MODE_CFG_WRITE))
    begin
      mode_q <= ep_cmd_pkg::MODE_IDLE;
    end
  end

  // ==========================================================================
  // Configuration byte
  // ==========================================================================
  // Written by the data byte after the set mode command
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      cfg_q <= `CFG_RESET;
    end
    else if (DATA_WR_I && (mode_q == ep_cmd_pkg::MODE_CFG_WRITE))
    begin
      cfg_q <= DATA_I;
    end
  end

  // ==========================================================================
  // Buffer pointer
  // ==========================================================================
  // Reset only by a select, advanced per buffer byte read
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ptr_q <= 5'h00;
    end
    else if (is_sel || is_selclr)
    begin
      ptr_q <= 5'h00;
    end
    else if (DATA_RD_I && (mode_q == ep_cmd_pkg::MODE_BUF_READ))
    begin
      ptr_q <= ptr_q + 5'h01;
    end
  end
  // Buffer storage filled from the USB side
  always_ff @(posedge CLK_I)
  begin
    if (BUF_WR_I)
    begin
      buf_mem[{BUF_WR_EP_I, BUF_WR_ADDR_I}] <= BUF_WR_DATA_I;
    end
  end

  // ==========================================================================
  // Endpoint state flags, one set per endpoint
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < `EP_COUNT; g = g + 1)
    begin : g_ep
      // Control endpoints are indexes 0 and 1 of each function
      localparam logic IS_CTRL = ((g % 4) < 2);
      // Odd indexes are IN buffers
      localparam logic IS_IN = ((g % 2) == 1);
      // Interrupt cause: success, or NAK when enabled on control
      assign ep_irq_set[g] = EP_DONE_I[g] ||
        (IS_CTRL && cfg_q[`CFG_NAK_IRQ_BIT] && EP_NAK_I[g]);
      // NAK flag, set wins over ACK
      always_ff @(posedge CLK_I or negedge RESETN_I)
      begin
        if (!RESETN_I)
        begin
          nak_q[g] <= 1'b0;
        end
        else if (IS_CTRL && cfg_q[`CFG_NAK_IRQ_BIT] && EP_NAK_I[g])
        begin
          nak_q[g] <= 1'b1;
        end
        else if (EP_ACK_I[g])
        begin
          nak_q[g] <= 1'b0;
        end
      end
      // Overwrite and setup flags, set wins over select-clear
      always_ff @(posedge CLK_I or negedge RESETN_I)
      begin
        if (!RESETN_I)
        begin
          ovw_q[g] <= 1'b0;
          setup_q[g] <= 1'b0;
        end
        else
        begin
          if (EP_OVW_I[g])
          begin
            ovw_q[g] <= 1'b1;
          end
          else if (clr_ep[g])
          begin
            ovw_q[g] <= 1'b0;
          end
          if (EP_SETUP_I[g] && !IS_IN)
          begin
            setup_q[g] <= 1'b1;
          end
          else if (clr_ep[g] || EP_DONE_I[g])
          begin
            setup_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // State byte of the selected endpoint
  always_comb
  begin
    state_byte = 8'h00;
    state_byte[`ST_NAK_BIT] = nak_q[sel_q];
    state_byte[`ST_OVW_BIT] = ovw_q[sel_q];
    state_byte[`ST_SETUP_BIT] = setup_q[sel_q];
    state_byte[`ST_STALL_BIT] = EP_STALL_I[sel_q];
    state_byte[`ST_FULL_BIT] = EP_FULL_I[sel_q];
  end

  // ==========================================================================
  // Interrupt source register
  // ==========================================================================
  // Endpoint bits map straight from endpoint index; set wins over clear
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      irq_q <= `IRQ_RESET;
    end
    else
    begin
      // Endpoint bits 11..0, no hub endpoint source exists
      irq_q[11:0] <= ep_irq_set | (irq_q[11:0] & ~clr_ep);
      // Port change bits 14..12
      irq_q[14:12] <= PORT_CHG_I | (irq_q[14:12] & ~rd_port);
      // Hub change bit 15
      irq_q[`IRQ_HUB_BIT] <= HUB_CHG_I | (irq_q[`IRQ_HUB_BIT] & ~rd_hub);
    end
  end
  // Request held while any source is pending
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      IRQ_O <= 1'b0;
    end
    else
    begin
      IRQ_O <= |irq_q;
    end
  end

  // ==========================================================================
  // Read data path
  // ==========================================================================
  // One byte answered the cycle after each read strobe
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      DATA_O <= 8'h00;
      DATA_VLD_O <= 1'b0;
    end
    else
    begin
      DATA_VLD_O <= DATA_RD_I;
      if (DATA_RD_I)
      begin
        case (mode_q)
          ep_cmd_pkg::MODE_IRQ_LO: DATA_O <= irq_q[7:0];
          ep_cmd_pkg::MODE_IRQ_HI: DATA_O <= irq_q[15:8];
          ep_cmd_pkg::MODE_EP_STATE: DATA_O <= state_byte;
          ep_cmd_pkg::MODE_BUF_READ: DATA_O <= buf_mem[{sel_q, ptr_q}];
          ep_cmd_pkg::MODE_HUB_STAT: DATA_O <= HUB_STATUS_I;
          ep_cmd_pkg::MODE_PORT_STAT: DATA_O <= PORT_STATUS_I[{port_q, 3'h0} +: 8];
          default: DATA_O <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_irq_low_first: assert property (
    (DATA_RD_I && !CMD_WR_I && mode_q == ep_cmd_pkg::MODE_IRQ_LO)
    |=> DATA_O == $past(irq_q[7:0]))
    else $error("Interrupt read did not return low byte first");
  a_hub_bit_set: assert property (
    HUB_CHG_I |=> irq_q[15])
    else $error("Hub change did not set bit 15");
  a_port_bits_set: assert property (
    PORT_CHG_I[2] |=> irq_q[14])
    else $error("Function 3 change did not set bit 14");
  a_ep_bit_set: assert property (
    EP_DONE_I[3] |=> irq_q[3])
    else $error("Endpoint event did not set its bit");
  a_hub_read_clear: assert property (
    (rd_hub && !HUB_CHG_I) |=> !irq_q[15])
    else $error("Hub status read did not clear bit 15");
  a_selclr_clear: assert property (
    (is_selclr && CMD_I[3:0] == 4'h5 && !EP_DONE_I[5] && !EP_NAK_I[5]) |=> !irq_q[5])
    else $error("Select-and-clear did not clear the endpoint bit");
  a_sel_ptr_reset: assert property (
    is_sel |=> (ptr_q == 5'h00) && (sel_q == $past(CMD_I[3:0])))
    else $error("Select did not reset pointer");
  a_ptr_advance: assert property (
    (DATA_RD_I && mode_q == ep_cmd_pkg::MODE_BUF_READ && !CMD_WR_I)
    |=> ptr_q == $past(ptr_q) + 5'h01)
    else $error("Pointer did not advance");
  a_in_no_setup: assert property (
    !setup_q[1] && !setup_q[3])
    else $error("Setup flag set on IN buffer");
  a_irq_held: assert property (
    (|irq_q) ##1 (|irq_q) |-> IRQ_O)
    else $error("Interrupt request not held");
  c_irq_read: cover property (
    (CMD_WR_I && CMD_I == `CMD_IRQ_READ) ##2 DATA_RD_I ##2 DATA_RD_I);
  c_buf_stream: cover property (
    is_sel ##2 (CMD_WR_I && CMD_I == `CMD_BUF_READ) ##2 DATA_RD_I ##2 DATA_RD_I);
  c_nak_flag: cover property (EP_NAK_I[0] ##1 nak_q[0]);
  c_set_over_clear: cover property (EP_DONE_I[5] && clr_ep[5]);

endmodule : endpoint_irq_and_buffer_read

// ---- src/ep_cmd_params.svh ----
// Constants for the endpoint interrupt and buffer read command block
`ifndef EP_CMD_PARAMS_SVH
`define EP_CMD_PARAMS_SVH

// Command codes
`define CMD_SEL_FIRST 8'h00
`define CMD_SEL_LAST 8'h0B
`define CMD_SELCLR_FIRST 8'h40
`define CMD_SELCLR_LAST 8'h4B
`define CMD_BUF_READ 8'hF0
`define CMD_SET_MODE 8'hF3
`define CMD_IRQ_READ 8'hF4
`define CMD_HUB_STAT 8'hFE
`define CMD_PORT_FIRST 8'hE0
`define CMD_PORT_LAST 8'hE2

// Interrupt source layout
`define IRQ_WIDTH 16
`define IRQ_RESET 16'h0000
`define IRQ_HUB_BIT 15
`define IRQ_PORT_BASE 12
`define EP_COUNT 12

// Endpoint buffer state byte positions
`define ST_NAK_BIT 4
`define ST_OVW_BIT 3
`define ST_SETUP_BIT 2
`define ST_STALL_BIT 1
`define ST_FULL_BIT 0

// Configuration byte
`define CFG_NAK_IRQ_BIT 0
`define CFG_RESET 8'h01

// Endpoint buffer storage: payload N plus two header bytes
`define BUF_PAYLOAD 16
`define BUF_PTR_W 5
`define BUF_SLOTS 32
`define BUF_DEPTH 384

`endif

// ---- src/ep_cmd_pkg.sv ----
// Types for the endpoint interrupt and buffer read command block
package ep_cmd_pkg;

  // Meaning of the next data byte read or written
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_IRQ_LO = 3'b001,
    MODE_IRQ_HI = 3'b010,
    MODE_EP_STATE = 3'b011,
    MODE_BUF_READ = 3'b100,
    MODE_HUB_STAT = 3'b101,
    MODE_PORT_STAT = 3'b110,
    MODE_CFG_WRITE = 3'b111
  } data_mode_t;

endpackage : ep_cmd_pkg

// ---- tb/mcu_model.sv ----
// Microcontroller core model that issues commands, data writes and data reads
`timescale 1ns/1ps

module mcu_model (
  input wire logic clk_i,
  output logic cmd_wr_o,
  output logic [7:0] cmd_o,
  output logic data_wr_o,
  output logic data_rd_o,
  output logic [7:0] data_o
);
  // ==========================================================
  // Idle state
  initial
  begin
    cmd_wr_o = 1'b0;
    cmd_o = 8'h5A;
    data_wr_o = 1'b0;
    data_rd_o = 1'b0;
    data_o = 8'hA5;
  end

  // ==========================================================
  // One strobe per call: kind 0 command, 1 data write, 2 data read
  task automatic strobe(input int kind, input logic [7:0] val);
    @(posedge clk_i);
    #2;
    case (kind)
      0: cmd_wr_o = 1'b1;
      1: data_wr_o = 1'b1;
      default: data_rd_o = 1'b1;
    endcase
    cmd_o = val;
    data_o = val;
    // Held until the taking edge, then released
    @(posedge clk_i);
    #2;
    cmd_wr_o = 1'b0;
    data_wr_o = 1'b0;
    data_rd_o = 1'b0;
    // Released lines show junk, not the last value
    cmd_o = ~val;
    data_o = ~val;
  endtask : strobe
endmodule : mcu_model

// ---- tb/testbench.sv ----
// Self-checking bench for the endpoint interrupt and buffer read block
`timescale 1ns/1ps

module testbench;
  // ==========================================================
  // Signals
  logic clk = 1'b0; // 20 MHz
  logic rst_n = 1'b0; // Active low reset
  logic cmd_wr, data_wr, data_rd, data_vld, irq, hub_chg, buf_wr;
  logic [7:0] cmd, wdata, rdata, hub_st, bwdata;
  logic [23:0] port_st;
  logic [2:0] port_chg;
  logic [11:0] done, nak, ack, setup, ovw, stall, full;
  logic [3:0] bep;
  logic [4:0] badr;
  logic [7:0] mem [0:17]; // Expected buffer image
  logic [7:0] exp_q [$]; // Notes of expected bytes
  logic [15:0] m;
  int err_count = 0;
  int checks = 0;
  int seed = 42127;

  always #25 clk = ~clk;

  // ==========================================================
  // Design and partner
  endpoint_irq_and_buffer_read endpoint_irq_and_buffer_read_i (
    .CLK_I(clk), .RESETN_I(rst_n), .CMD_WR_I(cmd_wr), .CMD_I(cmd),
    .DATA_WR_I(data_wr), .DATA_I(wdata), .DATA_RD_I(data_rd), .DATA_O(rdata),
    .DATA_VLD_O(data_vld), .IRQ_O(irq), .HUB_STATUS_I(hub_st),
    .PORT_STATUS_I(port_st), .HUB_CHG_I(hub_chg), .PORT_CHG_I(port_chg),
    .EP_DONE_I(done), .EP_NAK_I(nak), .EP_ACK_I(ack), .EP_SETUP_I(setup),
    .EP_OVW_I(ovw), .EP_STALL_I(stall), .EP_FULL_I(full), .BUF_WR_I(buf_wr),
    .BUF_WR_EP_I(bep), .BUF_WR_ADDR_I(badr), .BUF_WR_DATA_I(bwdata));

  mcu_model mcu_model_i (.clk_i(clk), .cmd_wr_o(cmd_wr), .cmd_o(cmd),
    .data_wr_o(data_wr), .data_rd_o(data_rd), .data_o(wdata));

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic tick;
    @(posedge clk);
    #2;
  endtask : tick

  // Note the expected byte, then read it
  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    mcu_model_i.strobe(2, 8'h00);
  endtask : rd

  task automatic cmd_rd(input logic [7:0] c, input logic [7:0] e);
    mcu_model_i.strobe(0, c);
    rd(e);
  endtask : cmd_rd

  // Interrupt register: low byte first
  task automatic irq_rd(input logic [15:0] e);
    cmd_rd(8'hF4, e[7:0]);
    rd(e[15:8]);
  endtask : irq_rd

  // One-cycle event pulse: 0 done, 1 nak, 2 ack, 3 setup, 4 overwrite
  task automatic ev(input int k, input logic [11:0] v);
    tick();
    case (k)
      0: done = v;
      1: nak = v;
      2: ack = v;
      3: setup = v;
      default: ovw = v;
    endcase
    tick();
    {done, nak, ack, setup, ovw} = '0;
  endtask : ev

  // ==========================================================
  // Monitor: oldest note against every returned byte
  always @(negedge clk)
  begin
    if (data_vld === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unsolicited byte", 16'h0001, 16'h0000);
      else
        check("read byte", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("unexpected timeout");
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {hub_chg, buf_wr, port_chg, done, nak, ack, setup, ovw, stall, full} = '0;
    bep = 4'h0;
    badr = 5'h00;
    bwdata = 8'h00;
    hub_st = 8'($random(seed));
    port_st = 24'($random(seed));
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'b1;
    check("irq level", {15'h0000, irq}, 16'h0000);
    irq_rd(16'h0000);
    $display("test reset done");
    // Random endpoint sources plus hub and port changes
    m = 16'($random(seed)) | 16'h0009;
    ev(0, m[11:0]);
    tick();
    hub_chg = 1'b1;
    port_chg = 3'h7;
    tick();
    hub_chg = 1'b0;
    port_chg = 3'h0;
    tick();
    check("irq level", {15'h0000, irq}, 16'h0001);
    irq_rd({4'hF, m[11:0]});
    cmd_rd(8'hFE, hub_st);
    for (int k = 0; k < 3; k++)
      cmd_rd(8'(8'hE0 + k), port_st[8*k +: 8]);
    irq_rd({4'h0, m[11:0]});
    for (int k = 0; k < 12; k++)
      cmd_rd(8'(8'h40 + k), 8'h00);
    irq_rd(16'h0000);
    tick();
    check("irq level", {15'h0000, irq}, 16'h0000);
    $display("test interrupt sources done");
    // Endpoint state byte flags
    stall = 12'h001;
    full = 12'h001;
    ev(3, 12'h003);
    ev(4, 12'h001);
    ev(1, 12'h005);
    cmd_rd(8'h00, 8'h1F);
    cmd_rd(8'h01, 8'h00);
    cmd_rd(8'h02, 8'h00);
    ev(2, 12'h001);
    cmd_rd(8'h00, 8'h0F);
    cmd_rd(8'h40, 8'h03);
    irq_rd(16'h0000);
    mcu_model_i.strobe(0, 8'hF3);
    mcu_model_i.strobe(1, 8'h00);
    ev(1, 12'h001);
    irq_rd(16'h0000);
    cmd_rd(8'h00, 8'h03);
    mcu_model_i.strobe(0, 8'hF3);
    mcu_model_i.strobe(1, 8'h01);
    ev(1, 12'h001);
    irq_rd(16'h0001);
    cmd_rd(8'h40, 8'h13);
    stall = 12'h000;
    full = 12'h000;
    $display("test state byte done");
    // Buffer of endpoint 5: flags, count, payload
    for (int k = 0; k < 18; k++)
    begin
      mem[k] = (k == 0) ? 8'h80 : (k == 1) ? 8'h10 : 8'($random(seed));
      tick();
      buf_wr = 1'b1;
      bep = 4'h5;
      badr = 5'(k);
      bwdata = mem[k];
    end
    tick();
    buf_wr = 1'b0;
    mcu_model_i.strobe(0, 8'h05);
    mcu_model_i.strobe(0, 8'hF0);
    for (int k = 0; k < 6; k++)
      rd(mem[k]);
    irq_rd(16'h0000);
    mcu_model_i.strobe(0, 8'hF0);
    for (int k = 6; k < 18; k++)
      rd(mem[k]);
    mcu_model_i.strobe(0, 8'h05);
    mcu_model_i.strobe(0, 8'hF0);
    rd(mem[0]);
    $display("test buffer read done");
    for (int k = 0; k < 10 && exp_q.size() > 0; k++)
      tick();
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule : testbench
